// ==== shared/pcb_pkg.sv ====
// Shared constants, bus types and helper functions for both bus ends.
// What this block does
// [R1] Drive sustained line high before releasing it.
// [R2] Wait one clock before driving released line.
// [R3] All bus outputs float while reset asserted.
// [R4] First FRAME low clock carries the address.
// [R5] I/O byte address; memory/config DWORD address.
// [R6] Little endian lanes, LSB on AD[7:0].
// [R7] 32-bit bus leaves upper half idle.
// [R8] CBE carries command, then byte enables.
// [R9] Byte enable n governs byte lane n.
// [R10] PAR is even parity of lower half.
// [R11] PAR64 is even parity of upper half.
// [R12] Parity valid one clock after AD drive.
// [R13] Master parities address/write, target parities reads.
// [R14] FRAME asserted to start, released at final.
// [R15] Phase completes when IRDY and TRDY low.
// [R16] IRDY: write data valid, read accept.
// [R17] TRDY: read data valid, write accept.
// [R18] Master drives IRDY; target drives TRDY.
package pcb_pkg;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [63:0] DEF_WIN_BASE = 64'h0000_0000_0001_0000;
  localparam logic [63:0] DEF_WIN_SIZE = 64'h0000_0000_0001_0000;
  localparam logic [31:0] LOW_KEEP = 32'hffff_ffff;
  localparam logic [3:0] LOW_BE_KEEP = 4'hf;

  typedef enum logic [2:0] {
    PCB_M_IDLE = 3'b000,
    PCB_M_ADDR = 3'b001,
    PCB_M_DATA = 3'b010,
    PCB_M_TURN = 3'b011,
    PCB_M_GAP = 3'b100
  } pcb_mst_st_t;

  typedef enum logic [1:0] {
    PCB_T_IDLE = 2'b00,
    PCB_T_WAIT = 2'b01,
    PCB_T_DATA = 2'b10,
    PCB_T_TURN = 2'b11
  } pcb_tgt_st_t;

  // What one end drives; each group has its own output enable.
  typedef struct packed {
    logic [63:0] ad;
    logic ad_lo_oe;
    logic ad_hi_oe;
    logic [7:0] cbe_n;
    logic cbe_lo_oe;
    logic cbe_hi_oe;
    logic par;
    logic par_oe;
    logic par64;
    logic par64_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
  } pcb_drv_t;

  // Resolved wire levels; an undriven line reads high.
  typedef struct packed {
    logic [63:0] ad;
    logic [7:0] cbe_n;
    logic par;
    logic par64;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
  } pcb_bus_t;

  function automatic logic pcb_pick(input logic ae, input logic av,
                                    input logic be, input logic bv);
    return ae ? av : (be ? bv : 1'b1);
  endfunction

  function automatic pcb_bus_t pcb_resolve(input pcb_drv_t a,
                                           input pcb_drv_t b);
    pcb_bus_t r;
    for (int i = 0; i < 32; i++) begin
      r.ad[i] = pcb_pick(a.ad_lo_oe, a.ad[i], b.ad_lo_oe, b.ad[i]);
      r.ad[i+32] = pcb_pick(a.ad_hi_oe, a.ad[i+32], b.ad_hi_oe, b.ad[i+32]);
    end
    for (int i = 0; i < 4; i++) begin
      r.cbe_n[i] = pcb_pick(a.cbe_lo_oe, a.cbe_n[i], b.cbe_lo_oe, b.cbe_n[i]);
      r.cbe_n[i+4] = pcb_pick(a.cbe_hi_oe, a.cbe_n[i+4], b.cbe_hi_oe,
                              b.cbe_n[i+4]);
    end
    r.par = pcb_pick(a.par_oe, a.par, b.par_oe, b.par);
    r.par64 = pcb_pick(a.par64_oe, a.par64, b.par64_oe, b.par64);
    r.frame_n = pcb_pick(a.frame_oe, a.frame_n, b.frame_oe, b.frame_n);
    r.irdy_n = pcb_pick(a.irdy_oe, a.irdy_n, b.irdy_oe, b.irdy_n);
    r.trdy_n = pcb_pick(a.trdy_oe, a.trdy_n, b.trdy_oe, b.trdy_n);
    return r;
  endfunction

  function automatic logic pcb_even_par(input logic [31:0] d,
                                        input logic [3:0] c);
    return ^{d, c};
  endfunction

  function automatic logic pcb_cmd_ok(input logic [3:0] c);
    return c inside {CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
                     CMD_CFG_RD, CMD_CFG_WR};
  endfunction

  function automatic logic pcb_cmd_rd(input logic [3:0] c);
    return c inside {CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD};
  endfunction

  function automatic logic pcb_cmd_io(input logic [3:0] c);
    return c inside {CMD_IO_RD, CMD_IO_WR};
  endfunction

  // I/O keeps the byte address; memory and config give a DWORD index.
  function automatic logic [63:0] pcb_addr_conv(input logic [3:0] c,
                                                input logic [63:0] a);
    return pcb_cmd_io(c) ? a : {2'b00, a[63:2]};
  endfunction

  function automatic logic [63:0] pcb_ad_keep(input logic b64);
    return {{32{b64}}, LOW_KEEP};
  endfunction

  function automatic logic [7:0] pcb_be_keep(input logic b64);
    return {{4{b64}}, LOW_BE_KEEP};
  endfunction

  function automatic logic [63:0] pcb_lane_mask(input logic [7:0] be);
    logic [63:0] m;
    for (int i = 0; i < 8; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction
endpackage

// ==== shared/pcb_if.sv ====
// Shared bus between the device end and the host end.
interface pcb_if;
  import pcb_pkg::*;
  pcb_drv_t dev_drv;
  pcb_drv_t host_drv;
  pcb_bus_t bus;

  assign bus = pcb_resolve(dev_drv, host_drv);

  modport dev_mp(output dev_drv, input bus);
  modport host_mp(output host_drv, input bus);
endinterface

// ==== design/pcb_dev_end.sv ====
// Device end of the bus: one-phase master and windowed target.
module pcb_dev_end
  import pcb_pkg::*;
#(
  parameter logic [63:0] WIN_BASE = DEF_WIN_BASE,
  parameter logic [63:0] WIN_SIZE = DEF_WIN_SIZE
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  // Bus
  pcb_if.dev_mp BUS,
  // Width strap
  input wire logic BUS64_IN,
  // Master request
  input wire logic M_REQ_IN,
  input wire logic [3:0] M_CMD_IN,
  input wire logic [63:0] M_ADDR_IN,
  input wire logic [63:0] M_WDATA_IN,
  input wire logic [7:0] M_BE_IN,
  // Master answer
  output logic M_BUSY_OUT,
  output logic M_DONE_OUT,
  output logic [63:0] M_RDATA_OUT,
  // Target side
  output logic T_SEL_OUT,
  output logic T_IO_OUT,
  output logic T_WRITE_OUT,
  output logic [63:0] T_ADDR_OUT,
  input wire logic [63:0] T_RDATA_IN,
  output logic T_WR_OUT,
  output logic T_RD_OUT,
  output logic [63:0] T_WDATA_OUT,
  output logic [7:0] T_BE_OUT
);
  typedef struct packed {
    pcb_mst_st_t mst;
    pcb_tgt_st_t tgt;
    pcb_drv_t drv;
    logic prev_frame_act;
    logic m_write;
    logic [63:0] m_wdata;
    logic [7:0] m_be;
    logic m_busy;
    logic m_done;
    logic [63:0] m_rdata;
    logic t_sel;
    logic t_io;
    logic t_write;
    logic [63:0] t_addr;
    logic t_wr;
    logic t_rd;
    logic [63:0] t_wdata;
    logic [7:0] t_be;
  } pcb_dev_st_t;

  pcb_dev_st_t st_ff;
  pcb_dev_st_t nxt_st;
  pcb_bus_t bus_in;
  logic [63:0] addr_in;
  logic [3:0] cmd_in;
  logic addr_phase;
  logic win_hit;

  assign bus_in = BUS.bus;
  assign cmd_in = bus_in.cbe_n[3:0];
  assign addr_in = bus_in.ad & pcb_ad_keep(BUS64_IN); // R7
  // The address phase is the first clock with FRAME low.
  assign addr_phase = !bus_in.frame_n && !st_ff.prev_frame_act; // R4
  assign win_hit = pcb_cmd_ok(cmd_in) && (addr_in >= WIN_BASE) &&
                   ((addr_in - WIN_BASE) < WIN_SIZE);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.m_done = 1'b0;
    nxt_st.t_wr = 1'b0;
    nxt_st.t_rd = 1'b0;
    nxt_st.prev_frame_act = !bus_in.frame_n;
    // Parity trails by one clock whatever this end put on AD.
    nxt_st.drv.par = pcb_even_par(bus_in.ad[31:0], bus_in.cbe_n[3:0]); // R10
    nxt_st.drv.par64 = pcb_even_par(bus_in.ad[63:32],
                                    bus_in.cbe_n[7:4]); // R11
    nxt_st.drv.par_oe = st_ff.drv.ad_lo_oe; // R12 R13
    nxt_st.drv.par64_oe = st_ff.drv.ad_hi_oe; // R12 R13

    case (st_ff.mst)
      PCB_M_IDLE: begin
        if (M_REQ_IN && st_ff.tgt == PCB_T_IDLE && bus_in.frame_n &&
            bus_in.irdy_n && !st_ff.prev_frame_act) begin
          nxt_st.mst = PCB_M_ADDR;
          nxt_st.m_busy = 1'b1;
          nxt_st.m_write = !pcb_cmd_rd(M_CMD_IN);
          nxt_st.m_wdata = M_WDATA_IN;
          nxt_st.m_be = M_BE_IN;
          nxt_st.drv.ad = M_ADDR_IN; // R4
          nxt_st.drv.ad_lo_oe = 1'b1;
          nxt_st.drv.ad_hi_oe = BUS64_IN; // R7
          nxt_st.drv.cbe_n = {M_CMD_IN, M_CMD_IN}; // R8
          nxt_st.drv.cbe_lo_oe = 1'b1;
          nxt_st.drv.cbe_hi_oe = BUS64_IN; // R7
          nxt_st.drv.frame_n = 1'b0; // R14
          nxt_st.drv.frame_oe = 1'b1;
          nxt_st.drv.irdy_n = 1'b1;
          nxt_st.drv.irdy_oe = 1'b1; // R18
        end
      end
      PCB_M_ADDR: begin
        // Only one data phase is issued, so it is also the final one.
        nxt_st.mst = PCB_M_DATA;
        nxt_st.drv.frame_n = 1'b1; // R14
        nxt_st.drv.irdy_n = 1'b0; // R16 R18
        nxt_st.drv.cbe_n = ~st_ff.m_be; // R8 R9
        nxt_st.drv.ad = st_ff.m_wdata; // R6
        nxt_st.drv.ad_lo_oe = st_ff.m_write; // R16
        nxt_st.drv.ad_hi_oe = st_ff.m_write && BUS64_IN; // R7
      end
      PCB_M_DATA: begin
        if (!bus_in.trdy_n) begin // R15 R18
          nxt_st.mst = PCB_M_TURN;
          nxt_st.m_done = 1'b1;
          if (!st_ff.m_write) begin
            nxt_st.m_rdata = bus_in.ad & pcb_ad_keep(BUS64_IN); // R17 R7
          end
          nxt_st.drv.ad_lo_oe = 1'b0;
          nxt_st.drv.ad_hi_oe = 1'b0;
          nxt_st.drv.cbe_lo_oe = 1'b0;
          nxt_st.drv.cbe_hi_oe = 1'b0;
          // FRAME was held high through the data phase before release.
          nxt_st.drv.frame_oe = 1'b0; // R1
          nxt_st.drv.irdy_n = 1'b1; // R1
        end
      end
      PCB_M_TURN: begin
        nxt_st.mst = PCB_M_GAP;
        nxt_st.drv.irdy_oe = 1'b0; // R1
      end
      PCB_M_GAP: begin
        // One clock off the bus before this end may drive again.
        nxt_st.mst = PCB_M_IDLE; // R2
        nxt_st.m_busy = 1'b0;
      end
      default: begin
        nxt_st.mst = PCB_M_IDLE;
      end
    endcase

    case (st_ff.tgt)
      PCB_T_IDLE: begin
        if (st_ff.mst == PCB_M_IDLE && addr_phase && win_hit) begin
          nxt_st.tgt = PCB_T_WAIT;
          nxt_st.t_sel = 1'b1;
          nxt_st.t_io = pcb_cmd_io(cmd_in);
          nxt_st.t_write = !pcb_cmd_rd(cmd_in);
          nxt_st.t_addr = pcb_addr_conv(cmd_in, addr_in); // R5
          // TRDY is first driven one clock after the address phase.
          nxt_st.drv.trdy_n = 1'b1; // R2
          nxt_st.drv.trdy_oe = 1'b1; // R18
        end
      end
      PCB_T_WAIT: begin
        // AD turnaround clock on reads; read data goes out next.
        nxt_st.tgt = PCB_T_DATA;
        nxt_st.drv.trdy_n = 1'b0; // R17 R18
        if (!st_ff.t_write) begin
          nxt_st.drv.ad = T_RDATA_IN; // R6
          nxt_st.drv.ad_lo_oe = 1'b1; // R13
          nxt_st.drv.ad_hi_oe = BUS64_IN; // R7
        end
      end
      PCB_T_DATA: begin
        if (!bus_in.irdy_n) begin // R15
          nxt_st.tgt = PCB_T_TURN;
          nxt_st.t_be = ~bus_in.cbe_n & pcb_be_keep(BUS64_IN); // R9 R7
          if (st_ff.t_write) begin
            nxt_st.t_wr = 1'b1;
            nxt_st.t_wdata = bus_in.ad &
              pcb_lane_mask(~bus_in.cbe_n & pcb_be_keep(BUS64_IN)); // R16 R9
          end else begin
            nxt_st.t_rd = 1'b1;
          end
          nxt_st.drv.trdy_n = 1'b1; // R1
          nxt_st.drv.ad_lo_oe = 1'b0;
          nxt_st.drv.ad_hi_oe = 1'b0;
        end
      end
      PCB_T_TURN: begin
        nxt_st.tgt = PCB_T_IDLE;
        nxt_st.t_sel = 1'b0;
        nxt_st.drv.trdy_oe = 1'b0; // R1
      end
      default: begin
        nxt_st.tgt = PCB_T_IDLE;
      end
    endcase
  end

  // Reset clears every output enable, so the bus floats throughout it.
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_ff <= '0; // R3
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign BUS.dev_drv = st_ff.drv;
  assign M_BUSY_OUT = st_ff.m_busy;
  assign M_DONE_OUT = st_ff.m_done;
  assign M_RDATA_OUT = st_ff.m_rdata;
  assign T_SEL_OUT = st_ff.t_sel;
  assign T_IO_OUT = st_ff.t_io;
  assign T_WRITE_OUT = st_ff.t_write;
  assign T_ADDR_OUT = st_ff.t_addr;
  assign T_WR_OUT = st_ff.t_wr;
  assign T_RD_OUT = st_ff.t_rd;
  assign T_WDATA_OUT = st_ff.t_wdata;
  assign T_BE_OUT = st_ff.t_be;
endmodule

// ==== design/pcb_host_end.sv ====
// Host end of the bus: one-phase master and catch-all target.
module pcb_host_end
  import pcb_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  // Bus
  pcb_if.host_mp BUS,
  // Width strap
  input wire logic BUS64_IN,
  // Master request
  input wire logic M_REQ_IN,
  input wire logic [3:0] M_CMD_IN,
  input wire logic [63:0] M_ADDR_IN,
  input wire logic [63:0] M_WDATA_IN,
  input wire logic [7:0] M_BE_IN,
  // Master answer
  output logic M_BUSY_OUT,
  output logic M_DONE_OUT,
  output logic [63:0] M_RDATA_OUT,
  // Target side
  output logic T_SEL_OUT,
  output logic T_IO_OUT,
  output logic T_WRITE_OUT,
  output logic [63:0] T_ADDR_OUT,
  input wire logic [63:0] T_RDATA_IN,
  output logic T_WR_OUT,
  output logic T_RD_OUT,
  output logic [63:0] T_WDATA_OUT,
  output logic [7:0] T_BE_OUT
);
  typedef struct packed {
    pcb_mst_st_t mst;
    pcb_tgt_st_t tgt;
    pcb_drv_t drv;
    logic prev_frame_act;
    logic m_write;
    logic [63:0] m_wdata;
    logic [7:0] m_be;
    logic m_busy;
    logic m_done;
    logic [63:0] m_rdata;
    logic t_sel;
    logic t_io;
    logic t_write;
    logic [63:0] t_addr;
    logic t_wr;
    logic t_rd;
    logic [63:0] t_wdata;
    logic [7:0] t_be;
  } pcb_host_st_t;

  pcb_host_st_t st_ff;
  pcb_host_st_t nxt_st;
  pcb_bus_t bus_in;
  logic [63:0] addr_in;
  logic [3:0] cmd_in;
  logic [7:0] be_in;

  assign bus_in = BUS.bus;
  assign cmd_in = bus_in.cbe_n[3:0];
  assign addr_in = bus_in.ad & pcb_ad_keep(BUS64_IN); // R7
  assign be_in = ~bus_in.cbe_n & pcb_be_keep(BUS64_IN); // R9

  always_comb begin
    nxt_st = st_ff;
    nxt_st.m_done = 1'b0;
    nxt_st.t_wr = 1'b0;
    nxt_st.t_rd = 1'b0;
    nxt_st.prev_frame_act = !bus_in.frame_n;
    nxt_st.drv.par = pcb_even_par(bus_in.ad[31:0], bus_in.cbe_n[3:0]); // R10
    nxt_st.drv.par64 = pcb_even_par(bus_in.ad[63:32],
                                    bus_in.cbe_n[7:4]); // R11
    nxt_st.drv.par_oe = st_ff.drv.ad_lo_oe; // R12 R13
    nxt_st.drv.par64_oe = st_ff.drv.ad_hi_oe; // R12 R13

    case (st_ff.mst)
      PCB_M_IDLE: begin
        if (M_REQ_IN && st_ff.tgt == PCB_T_IDLE && bus_in.frame_n &&
            bus_in.irdy_n && !st_ff.prev_frame_act) begin
          nxt_st.mst = PCB_M_ADDR;
          nxt_st.m_busy = 1'b1;
          nxt_st.m_write = !pcb_cmd_rd(M_CMD_IN);
          nxt_st.m_wdata = M_WDATA_IN;
          nxt_st.m_be = M_BE_IN;
          nxt_st.drv.ad = M_ADDR_IN; // R4
          nxt_st.drv.ad_lo_oe = 1'b1;
          nxt_st.drv.ad_hi_oe = BUS64_IN; // R7
          nxt_st.drv.cbe_n = {M_CMD_IN, M_CMD_IN}; // R8
          nxt_st.drv.cbe_lo_oe = 1'b1;
          nxt_st.drv.cbe_hi_oe = BUS64_IN;
          nxt_st.drv.frame_n = 1'b0; // R14
          nxt_st.drv.frame_oe = 1'b1;
          nxt_st.drv.irdy_n = 1'b1;
          nxt_st.drv.irdy_oe = 1'b1;
        end
      end
      PCB_M_ADDR: begin
        nxt_st.mst = PCB_M_DATA;
        nxt_st.drv.frame_n = 1'b1; // R14
        nxt_st.drv.irdy_n = 1'b0; // R16
        nxt_st.drv.cbe_n = ~st_ff.m_be; // R8 R9
        nxt_st.drv.ad = st_ff.m_wdata; // R6
        nxt_st.drv.ad_lo_oe = st_ff.m_write;
        nxt_st.drv.ad_hi_oe = st_ff.m_write && BUS64_IN;
      end
      PCB_M_DATA: begin
        if (!bus_in.trdy_n) begin // R15
          nxt_st.mst = PCB_M_TURN;
          nxt_st.m_done = 1'b1;
          if (!st_ff.m_write) begin
            nxt_st.m_rdata = addr_in; // R17
          end
          nxt_st.drv.ad_lo_oe = 1'b0;
          nxt_st.drv.ad_hi_oe = 1'b0;
          nxt_st.drv.cbe_lo_oe = 1'b0;
          nxt_st.drv.cbe_hi_oe = 1'b0;
          nxt_st.drv.frame_oe = 1'b0; // R1
          nxt_st.drv.irdy_n = 1'b1; // R1
        end
      end
      PCB_M_TURN: begin
        nxt_st.mst = PCB_M_GAP;
        nxt_st.drv.irdy_oe = 1'b0; // R1
      end
      PCB_M_GAP: begin
        nxt_st.mst = PCB_M_IDLE; // R2
        nxt_st.m_busy = 1'b0;
      end
      default: begin
        nxt_st.mst = PCB_M_IDLE;
      end
    endcase

    case (st_ff.tgt)
      PCB_T_IDLE: begin
        // Claims every valid command that this end did not start.
        if (st_ff.mst == PCB_M_IDLE && !bus_in.frame_n &&
            !st_ff.prev_frame_act && pcb_cmd_ok(cmd_in)) begin // R4
          nxt_st.tgt = PCB_T_WAIT;
          nxt_st.t_sel = 1'b1;
          nxt_st.t_io = pcb_cmd_io(cmd_in);
          nxt_st.t_write = !pcb_cmd_rd(cmd_in);
          nxt_st.t_addr = pcb_addr_conv(cmd_in, addr_in); // R5
          nxt_st.drv.trdy_n = 1'b1; // R2
          nxt_st.drv.trdy_oe = 1'b1;
        end
      end
      PCB_T_WAIT: begin
        nxt_st.tgt = PCB_T_DATA;
        nxt_st.drv.trdy_n = 1'b0; // R17
        if (!st_ff.t_write) begin
          nxt_st.drv.ad = T_RDATA_IN; // R6
          nxt_st.drv.ad_lo_oe = 1'b1; // R13
          nxt_st.drv.ad_hi_oe = BUS64_IN; // R7
        end
      end
      PCB_T_DATA: begin
        if (!bus_in.irdy_n) begin // R15
          nxt_st.tgt = PCB_T_TURN;
          nxt_st.t_be = be_in;
          nxt_st.t_wr = st_ff.t_write;
          nxt_st.t_rd = !st_ff.t_write;
          if (st_ff.t_write) begin
            nxt_st.t_wdata = bus_in.ad & pcb_lane_mask(be_in); // R16 R9
          end
          nxt_st.drv.trdy_n = 1'b1; // R1
          nxt_st.drv.ad_lo_oe = 1'b0;
          nxt_st.drv.ad_hi_oe = 1'b0;
        end
      end
      PCB_T_TURN: begin
        nxt_st.tgt = PCB_T_IDLE;
        nxt_st.t_sel = 1'b0;
        nxt_st.drv.trdy_oe = 1'b0; // R1
      end
      default: begin
        nxt_st.tgt = PCB_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign BUS.host_drv = st_ff.drv;
  assign M_BUSY_OUT = st_ff.m_busy;
  assign M_DONE_OUT = st_ff.m_done;
  assign M_RDATA_OUT = st_ff.m_rdata;
  assign T_SEL_OUT = st_ff.t_sel;
  assign T_IO_OUT = st_ff.t_io;
  assign T_WRITE_OUT = st_ff.t_write;
  assign T_ADDR_OUT = st_ff.t_addr;
  assign T_WR_OUT = st_ff.t_wr;
  assign T_RD_OUT = st_ff.t_rd;
  assign T_WDATA_OUT = st_ff.t_wdata;
  assign T_BE_OUT = st_ff.t_be;
endmodule

// ==== tb/pcb_checker.sv ====
// Concurrent checks on the shared bus between the two ends.
module pcb_checker
  import pcb_pkg::*;
(
  // Clock, reset and width strap
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic BUS64_IN,
  // Interface signals
  input wire pcb_drv_t dev_drv,
  input wire pcb_drv_t host_drv,
  input wire pcb_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  function automatic logic any_oe(input pcb_drv_t d);
    return d.ad_lo_oe | d.ad_hi_oe | d.cbe_lo_oe | d.cbe_hi_oe | d.par_oe |
           d.par64_oe | d.frame_oe | d.irdy_oe | d.trdy_oe;
  endfunction

  function automatic logic hi_oe(input pcb_drv_t d);
    return d.ad_hi_oe | d.cbe_hi_oe | d.par64_oe;
  endfunction

  a_reset_float: assert property (disable iff (1'b0) !NRST_IN |->
    !any_oe(dev_drv) && !any_oe(host_drv)) else $error("driven in reset");
  a_frame_release: assert property (
    (!$fell(dev_drv.frame_oe) || $past(dev_drv.frame_n)) &&
    (!$fell(host_drv.frame_oe) || $past(host_drv.frame_n)))
    else $error("frame released while low");
  a_irdy_release: assert property (
    (!$fell(dev_drv.irdy_oe) || $past(dev_drv.irdy_n)) &&
    (!$fell(host_drv.irdy_oe) || $past(host_drv.irdy_n)))
    else $error("irdy released while low");
  a_trdy_release: assert property (
    (!$fell(dev_drv.trdy_oe) || $past(dev_drv.trdy_n)) &&
    (!$fell(host_drv.trdy_oe) || $past(host_drv.trdy_n)))
    else $error("trdy released while low");
  a_turn_gap: assert property (
    ($fell(dev_drv.ad_lo_oe) || $fell(host_drv.ad_lo_oe)) |->
    !(dev_drv.ad_lo_oe || host_drv.ad_lo_oe)) else $error("no turn gap");
  a_frame_single: assert property ($fell(bus.frame_n) |=>
    bus.frame_n && !bus.irdy_n) else $error("frame not single phase");
  a_phase_done: assert property (!bus.irdy_n && !bus.trdy_n |=>
    bus.irdy_n && bus.trdy_n) else $error("ready held past completion");
  a_ready_soon: assert property ($fell(bus.irdy_n) |->
    ##[1:8] !bus.trdy_n) else $error("target never ready");
  a_par_lo: assert property (dev_drv.par_oe || host_drv.par_oe |->
    bus.par == ^{$past(bus.ad[31:0]), $past(bus.cbe_n[3:0])})
    else $error("low parity wrong");
  a_par_hi: assert property (dev_drv.par64_oe || host_drv.par64_oe |->
    bus.par64 == ^{$past(bus.ad[63:32]), $past(bus.cbe_n[7:4])})
    else $error("high parity wrong");
  a_par_owner: assert property (
    (!dev_drv.par_oe || $past(dev_drv.ad_lo_oe)) &&
    (!host_drv.par_oe || $past(host_drv.ad_lo_oe)))
    else $error("parity from wrong end");
  a_narrow_idle: assert property (!BUS64_IN |->
    !hi_oe(dev_drv) && !hi_oe(host_drv)) else $error("upper half driven");
endmodule

// ==== tb/pci_bus_signal_protocol_bench.sv ====
// Self-checking bench joining the device end and the host end.
module pci_bus_signal_protocol_bench import pcb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, bus64;
  logic m_req [2];
  logic m_busy [2], m_done [2], t_sel [2], t_io [2], t_write [2];
  logic t_wr [2], t_rd [2];
  logic [3:0] m_cmd [2];
  logic [7:0] m_be [2], t_be [2];
  logic [63:0] m_addr [2], m_wdata [2], t_rdata [2], m_rdata [2];
  logic [63:0] t_addr [2], t_wdata [2];
  // Reference model: expected address, byte enables and data, in order.
  logic [63:0] exp_q [$];
  logic [3:0] cmds [6] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
                           CMD_CFG_RD, CMD_CFG_WR};
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed;

  pcb_if bus_i ();

  pcb_dev_end i_pcb_dev_end (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .BUS(bus_i.dev_mp), .BUS64_IN(bus64), .M_REQ_IN(m_req[0]),
    .M_CMD_IN(m_cmd[0]), .M_ADDR_IN(m_addr[0]), .M_WDATA_IN(m_wdata[0]),
    .M_BE_IN(m_be[0]), .M_BUSY_OUT(m_busy[0]), .M_DONE_OUT(m_done[0]),
    .M_RDATA_OUT(m_rdata[0]), .T_SEL_OUT(t_sel[0]), .T_IO_OUT(t_io[0]),
    .T_WRITE_OUT(t_write[0]), .T_ADDR_OUT(t_addr[0]),
    .T_RDATA_IN(t_rdata[0]), .T_WR_OUT(t_wr[0]), .T_RD_OUT(t_rd[0]),
    .T_WDATA_OUT(t_wdata[0]), .T_BE_OUT(t_be[0]));

  pcb_host_end i_pcb_host_end (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .BUS(bus_i.host_mp), .BUS64_IN(bus64), .M_REQ_IN(m_req[1]),
    .M_CMD_IN(m_cmd[1]), .M_ADDR_IN(m_addr[1]), .M_WDATA_IN(m_wdata[1]),
    .M_BE_IN(m_be[1]), .M_BUSY_OUT(m_busy[1]), .M_DONE_OUT(m_done[1]),
    .M_RDATA_OUT(m_rdata[1]), .T_SEL_OUT(t_sel[1]), .T_IO_OUT(t_io[1]),
    .T_WRITE_OUT(t_write[1]), .T_ADDR_OUT(t_addr[1]),
    .T_RDATA_IN(t_rdata[1]), .T_WR_OUT(t_wr[1]), .T_RD_OUT(t_rd[1]),
    .T_WDATA_OUT(t_wdata[1]), .T_BE_OUT(t_be[1]));

  pcb_checker i_pcb_checker (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .BUS64_IN(bus64), .dev_drv(bus_i.dev_drv), .host_drv(bus_i.host_drv),
    .bus(bus_i.bus));

  always #10 clk = ~clk;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung transfer ends the run instead of stalling it.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("ERROR %0t: run took too long", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Resets both ends with a new width strap and checks the bus floats.
  task automatic do_reset(input logic w);
    @(posedge clk);
    #1;
    nrst = 1'b0;
    bus64 = w;
    repeat (3) @(posedge clk);
    #1;
    check(bus_i.bus.ad, '1);
    check(64'(bus_i.bus[12:0]), 64'h1fff);
    nrst = 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // One transaction from end m to the other end, checked against the model.
  task automatic xfer(input int m, input logic [3:0] cmd);
    int t;
    int n;
    logic [63:0] a, w, r, msk, ea;
    logic [7:0] be, k;
    logic rd, io;
    t = 1 - m;
    n = 0;
    a = {$random(seed), $random(seed)};
    if (t == 0) begin
      a = {48'h0000_0000_0001, a[15:0]};
    end
    w = {$random(seed), $random(seed)};
    r = {$random(seed), $random(seed)};
    be = 8'($random(seed));
    k = bus64 ? 8'hff : 8'h0f;
    rd = cmd inside {CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD};
    io = cmd inside {CMD_IO_RD, CMD_IO_WR};
    for (int i = 0; i < 8; i++) begin
      msk[8*i +: 8] = {8{be[i] & k[i]}};
    end
    ea = bus64 ? a : {32'h0, a[31:0]};
    if (!io) begin
      ea = ea >> 2;
    end
    exp_q.push_back(ea);
    exp_q.push_back(64'(be & k));
    exp_q.push_back(rd ? r & msk : w & msk);
    @(posedge clk);
    #1;
    m_cmd[m] = cmd;
    m_addr[m] = a;
    m_wdata[m] = w;
    m_be[m] = be;
    t_rdata[t] = r;
    m_req[m] = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (m_busy[m] !== 1'b1 && n < 20);
    m_req[m] = 1'b0;
    while (m_done[m] !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(64'(m_done[m]), 64'h1);
    check(64'(t_sel[t]), 64'h1);
    check(64'(t_sel[m]), 64'h0);
    check(t_addr[t], exp_q.pop_front());
    check(64'({t_io[t], t_write[t]}), 64'({io, !rd}));
    check(64'(t_be[t]), exp_q.pop_front());
    if (rd) begin
      check(64'({t_wr[t], t_rd[t]}), 64'h1);
      check(m_rdata[m] & msk, exp_q.pop_front());
    end else begin
      check(64'({t_wr[t], t_rd[t]}), 64'h2);
      check(t_wdata[t], exp_q.pop_front());
    end
    while (m_busy[m] !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(64'(m_busy[m]), 64'h0);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus64 = 1'b1;
    seed = 32'h4aac;
    for (int i = 0; i < 2; i++) begin
      m_req[i] = 1'b0;
      m_cmd[i] = 4'h0;
      m_addr[i] = 64'h0;
      m_wdata[i] = 64'h0;
      m_be[i] = 8'h0;
      t_rdata[i] = 64'h0;
    end
    for (int w = 1; w >= 0; w--) begin
      do_reset(w[0]);
      for (int m = 0; m < 2; m++) begin
        foreach (cmds[c]) begin
          xfer(m, cmds[c]);
        end
        $display("Done: master end %0d, wide bus %0d", m, w);
      end
    end
    // Outside its window the device stays deselected; reset ends the hang.
    @(posedge clk);
    #1;
    m_cmd[1] = CMD_MEM_RD;
    m_addr[1] = 64'h0;
    m_req[1] = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(64'({t_sel[0], m_done[1]}), 64'h0);
    m_req[1] = 1'b0;
    do_reset(1'b1);
    $display("Done: address outside window refused");
    give_verdict();
  end
endmodule
